// ===== cpu_config_params.svh
// constants for the processor configuration register bank
`ifndef CPU_CONFIG_PARAMS_SVH
`define CPU_CONFIG_PARAMS_SVH

// register byte offsets
`define CFG_OFF_VARIANT_A 8'h00
`define CFG_OFF_VARIANT_B 8'h04
`define CFG_OFF_STATUS 8'h08

// field positions
`define CFG_POLICY_LSB 0
`define CFG_DLINE_BIT 4
`define CFG_ILINE_BIT 5
`define CFG_DSIZE_LSB 6
`define CFG_ISIZE_LSB 9
`define CFG_ENDIAN_BIT 15
`define CFG_BUSW_BIT 23
`define CFG_PATTERN_LSB 24
`define CFG_RATIO_LSB 28

// fixed field values
`define CFG_SIZE_CODE_A 3'h2
`define CFG_SIZE_CODE_B 3'h1
`define CFG_LINE_CODE 1'h1
`define CFG_RESERVED_VALUE 32'h00000000
`define CFG_POLICY_RESET 3'h2

// code limits
`define CFG_RATIO_RESERVED 3'h7
`define CFG_PATTERN_LAST 4'h8
`define CFG_RATIO_OFFSET 4'h2

// bus answers
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

// ===== cpu_config_pkg.sv
// types for the processor configuration register bank
`default_nettype none
package cpu_config_pkg;

  typedef enum {SEL_VARIANT_A, SEL_VARIANT_B, SEL_STATUS, SEL_NONE} reg_sel_t;

  typedef struct packed {
    logic [3:0] len;
    logic [7:0] mask;
  } cadence_t;

  typedef struct packed {
    logic awHeld;
    logic [7:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic [2:0] clockRatioCode;
    logic [3:0] writebackPattern;
    logic busWidthSelect;
    logic endianSelect;
    logic variantB;
    logic beatIsWord;
    logic [2:0] policyA;
    logic [2:0] policyB;
    logic [3:0] divCount;
    logic sysEn;
    logic [2:0] slotPos;
    logic slotValid;
  } state_t;

endpackage
`default_nettype wire

// ===== cpu_configuration_register.sv
// processor configuration register bank with axi4-lite slave
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`include "cpu_config_params.svh"
`default_nettype none
module cpu_configuration_register (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // reset-time settings
  input wire logic variantStrap,
  input wire logic [2:0] clockRatioStrap,
  input wire logic [3:0] writebackPatternStrap,
  input wire logic busWidthStrap,
  input wire logic endianStrap,
  // writeback cadence
  input wire logic writebackActive,
  output logic systemClockEnable,
  output logic writebackSlot,
  output logic writebackBeatIsWord,
  // policy to the cache controller
  output logic [2:0] unmappedSegmentCachePolicy
);

  cpu_config_pkg::state_t s_reg;
  cpu_config_pkg::state_t s_next;
  cpu_config_pkg::cadence_t cad;
  cpu_config_pkg::reg_sel_t wrSel;
  cpu_config_pkg::reg_sel_t rdSel;
  logic [3:0] divLimit;
  logic ratioReserved;
  logic patternReserved;
  logic doWrite;

  // unaligned or unknown addresses land on SEL_NONE
  function automatic cpu_config_pkg::reg_sel_t decodeReg(input logic [7:0] addr);
    cpu_config_pkg::reg_sel_t sel;
    sel = cpu_config_pkg::SEL_NONE;
    case (addr)
      `CFG_OFF_VARIANT_A: sel = cpu_config_pkg::SEL_VARIANT_A;
      `CFG_OFF_VARIANT_B: sel = cpu_config_pkg::SEL_VARIANT_B;
      `CFG_OFF_STATUS: sel = cpu_config_pkg::SEL_STATUS;
      default: sel = cpu_config_pkg::SEL_NONE;
    endcase
    return sel;
  endfunction

  // slot masks, bit 0 is the first cycle of the period
  function automatic cpu_config_pkg::cadence_t cadenceOf(input logic isB, input logic [3:0] code);
    cpu_config_pkg::cadence_t c;
    c.len = 4'h1;
    c.mask = 8'h01;
    case (code)
      4'h0: begin
        c.len = 4'h1;
        c.mask = 8'h01;
      end
      4'h1: begin
        c.len = 4'h3;
        c.mask = 8'h03;
      end
      4'h2: begin
        c.len = 4'h4;
        c.mask = 8'h03;
      end
      4'h3: begin
        c.len = 4'h4;
        c.mask = 8'h05;
      end
      4'h4: begin
        c.len = 4'h5;
        c.mask = 8'h03;
      end
      4'h5: begin
        c.len = 4'h6;
        c.mask = 8'h03;
      end
      4'h6: begin
        // variant B spreads this pair over seven cycles
        c.len = isB ? 4'h7 : 4'h6;
        c.mask = 8'h09;
      end
      4'h7: begin
        c.len = 4'h7;
        c.mask = 8'h03;
      end
      4'h8: begin
        c.len = 4'h8;
        c.mask = 8'h11;
      end
      default: begin
        // reserved codes send nothing
        c.len = 4'h1;
        c.mask = 8'h00;
      end
    endcase
    return c;
  endfunction

  // one word for either variant; reserved bits come from a fixed pattern
  function automatic logic [31:0] composeConfig(input cpu_config_pkg::state_t st, input logic isB);
    logic [31:0] v;
    v = `CFG_RESERVED_VALUE;
    v[`CFG_RATIO_LSB +: 3] = st.clockRatioCode;
    v[`CFG_PATTERN_LSB +: 4] = st.writebackPattern;
    v[`CFG_BUSW_BIT] = isB ? st.busWidthSelect : 1'b0;
    v[`CFG_ENDIAN_BIT] = st.endianSelect;
    v[`CFG_ISIZE_LSB +: 3] = isB ? `CFG_SIZE_CODE_B : `CFG_SIZE_CODE_A;
    v[`CFG_DSIZE_LSB +: 3] = isB ? `CFG_SIZE_CODE_B : `CFG_SIZE_CODE_A;
    v[`CFG_ILINE_BIT] = `CFG_LINE_CODE;
    v[`CFG_DLINE_BIT] = `CFG_LINE_CODE;
    v[`CFG_POLICY_LSB +: 3] = isB ? st.policyB : st.policyA;
    return v;
  endfunction

  assign wrSel = decodeReg(s_reg.awAddr);
  assign rdSel = decodeReg(araddr);
  assign cad = cadenceOf(s_reg.variantB, s_reg.writebackPattern);
  assign divLimit = {1'b0, s_reg.clockRatioCode} + `CFG_RATIO_OFFSET;
  assign ratioReserved = s_reg.clockRatioCode == `CFG_RATIO_RESERVED;
  assign patternReserved = s_reg.writebackPattern > `CFG_PATTERN_LAST;

  // one write and one read at a time; refuse new channels until the response drains
  assign awready = !s_reg.awHeld && !s_reg.bValid;
  assign wready = !s_reg.wHeld && !s_reg.bValid;
  assign arready = !s_reg.rValid;
  assign doWrite = s_reg.awHeld && s_reg.wHeld && !s_reg.bValid;

  always_comb begin
    s_next = s_reg;

    // write address and data may arrive in either order
    if (awvalid && awready) begin
      s_next.awHeld = 1'b1;
      s_next.awAddr = awaddr;
    end
    if (wvalid && wready) begin
      s_next.wHeld = 1'b1;
      s_next.wData = wdata;
      s_next.wStrb = wstrb;
    end

    if (s_reg.bValid && bready) begin
      s_next.bValid = 1'b0;
    end

    if (doWrite) begin
      s_next.awHeld = 1'b0;
      s_next.wHeld = 1'b0;
      s_next.bValid = 1'b1;
      s_next.bResp = `AXI_RESP_OKAY;
      case (wrSel)
        cpu_config_pkg::SEL_VARIANT_A: begin
          // only byte lane 0 carries writable bits
          if (s_reg.wStrb[0]) begin
            s_next.policyA = s_reg.wData[`CFG_POLICY_LSB +: 3];
          end
        end
        cpu_config_pkg::SEL_VARIANT_B: begin
          if (s_reg.wStrb[0]) begin
            s_next.policyB = s_reg.wData[`CFG_POLICY_LSB +: 3];
          end
        end
        cpu_config_pkg::SEL_STATUS: begin
          // status is read-only, write accepted and dropped
          s_next.bResp = `AXI_RESP_OKAY;
        end
        default: begin
          s_next.bResp = `AXI_RESP_SLVERR;
        end
      endcase
    end

    // read channel
    if (s_reg.rValid && rready) begin
      s_next.rValid = 1'b0;
    end
    if (arvalid && arready) begin
      s_next.rValid = 1'b1;
      s_next.rResp = `AXI_RESP_OKAY;
      case (rdSel)
        cpu_config_pkg::SEL_VARIANT_A: begin
          s_next.rData = composeConfig(s_reg, 1'b0);
        end
        cpu_config_pkg::SEL_VARIANT_B: begin
          s_next.rData = composeConfig(s_reg, 1'b1);
        end
        cpu_config_pkg::SEL_STATUS: begin
          s_next.rData = {28'h0000000, s_reg.sysEn, s_reg.variantB, patternReserved, ratioReserved};
        end
        default: begin
          s_next.rData = 32'h00000000;
          s_next.rResp = `AXI_RESP_SLVERR;
        end
      endcase
    end

    // system clock divider: one enable every code+2 core cycles
    if (ratioReserved) begin
      // reserved ratio stops the enable rather than guess a rate
      s_next.divCount = 4'h0;
      s_next.sysEn = 1'b0;
    end else if (s_reg.divCount >= divLimit - 4'h1) begin
      s_next.divCount = 4'h0;
      s_next.sysEn = 1'b1;
    end else begin
      s_next.divCount = s_reg.divCount + 4'h1;
      s_next.sysEn = 1'b0;
    end

    // writeback cadence, one slot per system clock
    // word and doubleword beats share the slot masks; width only changes the beat
    if (!writebackActive || patternReserved) begin
      s_next.slotPos = 3'h0;
      s_next.slotValid = 1'b0;
    end else if (s_reg.sysEn) begin
      s_next.slotValid = cad.mask[s_reg.slotPos];
      if ({1'b0, s_reg.slotPos} + 4'h1 >= cad.len) begin
        s_next.slotPos = 3'h0;
      end else begin
        s_next.slotPos = s_reg.slotPos + 3'h1;
      end
    end else begin
      s_next.slotValid = 1'b0;
    end

    // settings are sampled while reset is held and frozen afterwards
    if (rst) begin
      s_next.awHeld = 1'b0;
      s_next.awAddr = 8'h00;
      s_next.wHeld = 1'b0;
      s_next.wData = 32'h00000000;
      s_next.wStrb = 4'h0;
      s_next.bValid = 1'b0;
      s_next.bResp = `AXI_RESP_OKAY;
      s_next.rValid = 1'b0;
      s_next.rData = 32'h00000000;
      s_next.rResp = `AXI_RESP_OKAY;
      s_next.clockRatioCode = clockRatioStrap;
      s_next.writebackPattern = writebackPatternStrap;
      s_next.busWidthSelect = busWidthStrap;
      s_next.endianSelect = endianStrap;
      s_next.variantB = variantStrap;
      s_next.beatIsWord = variantStrap && busWidthStrap;
      // software must still write the policy; this value only avoids unknowns
      s_next.policyA = `CFG_POLICY_RESET;
      s_next.policyB = `CFG_POLICY_RESET;
      s_next.divCount = 4'h0;
      s_next.sysEn = 1'b0;
      s_next.slotPos = 3'h0;
      s_next.slotValid = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    s_reg <= s_next;
  end

  // bus outputs
  assign bvalid = s_reg.bValid;
  assign bresp = s_reg.bResp;
  assign rvalid = s_reg.rValid;
  assign rdata = s_reg.rData;
  assign rresp = s_reg.rResp;

  // block outputs
  assign systemClockEnable = s_reg.sysEn;
  assign writebackSlot = s_reg.slotValid;
  assign writebackBeatIsWord = s_reg.beatIsWord;
  assign unmappedSegmentCachePolicy = s_reg.variantB ? s_reg.policyB : s_reg.policyA;

endmodule // cpu_configuration_register
`default_nettype wire

// ===== cpu_configuration_register_props.sv
// assertions for the configuration register bank
`default_nettype none
module cpu_config_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  // settings and cadence
  input wire logic variantStrap,
  input wire logic [2:0] clockRatioStrap,
  input wire logic busWidthStrap,
  input wire logic systemClockEnable,
  input wire logic writebackSlot,
  input wire logic writebackBeatIsWord
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // settings as seen at reset; later strap moves must not matter
  logic [2:0] capRatio_reg;
  logic capWord_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      capRatio_reg <= clockRatioStrap;
      capWord_reg <= variantStrap & busWidthStrap;
    end
  end
  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  property p_w_answer;
    awvalid && awready && wvalid && wready |-> ##[1:2] bvalid;
  endproperty
  a_w_answer: assert property (p_w_answer) else $error("write response late");
  property p_r_answer;
    arvalid && arready |=> rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("read data late");
  property p_w_refused;
    bvalid |-> !awready && !wready;
  endproperty
  a_w_refused: assert property (p_w_refused) else $error("write taken during response");
  property p_ar_refused;
    rvalid |-> !arready;
  endproperty
  a_ar_refused: assert property (p_ar_refused) else $error("read taken during data");
  property p_ratio_fast;
    systemClockEnable && capRatio_reg == 3'h0 |=> !systemClockEnable ##1 systemClockEnable;
  endproperty
  a_ratio_fast: assert property (p_ratio_fast) else $error("enable period wrong");
  property p_ratio_reserved;
    capRatio_reg == 3'h7 |-> !systemClockEnable;
  endproperty
  a_ratio_reserved: assert property (p_ratio_reserved) else $error("enable on reserved ratio");
  property p_slot_after;
    writebackSlot |-> $past(systemClockEnable);
  endproperty
  a_slot_after: assert property (p_slot_after) else $error("slot without enable");
  property p_beat;
    !$past(rst) |-> writebackBeatIsWord == capWord_reg;
  endproperty
  a_beat: assert property (p_beat) else $error("beat width wrong");
  c_write: cover property (bvalid && bready);
  c_read: cover property (rvalid && rready);
  c_slot: cover property (writebackSlot);
endmodule // cpu_config_checker
bind cpu_configuration_register cpu_config_checker u_cpu_config_checker (.*);
`default_nettype wire

// ===== test_cpu_configuration_register.sv
// self-checking bench for the configuration register bank
`default_nettype none
module test_cpu_configuration_register;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, writebackPatternStrap, sPat;
  logic [1:0] bresp, rresp;
  logic variantStrap, busWidthStrap, endianStrap, writebackActive;
  logic systemClockEnable, writebackSlot, writebackBeatIsWord, sVar, sBw, sEn;
  logic [2:0] clockRatioStrap, unmappedSegmentCachePolicy, sRatio, polA, polB;
  int nFail, numChecks;
  cpu_configuration_register u_cpu_configuration_register (.*, .awprot(3'h0), .arprot(3'h0));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      nFail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", numChecks, nFail);
    if (nFail == 0 && numChecks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // master moves right after a rising edge and takes each answer at that edge; only the watchdog ends a wait
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic b;
    b = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    while (!b) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        b = 1'b1;
        r = bresp;
        bready <= 1'b0;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic k;
    k = 1'b0;
    @(posedge clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    while (!k) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        k = 1'b1;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end
  endtask
  function automatic logic [31:0] expReg(input logic b, input logic [2:0] pol);
    logic [2:0] sz;
    sz = b ? 3'h1 : 3'h2; // size code per variant
    return {1'b0, sRatio, sPat, b & sBw, 7'h00, sEn, 3'h0, sz, sz, 2'h3, 1'b0, pol}; // lines
  endfunction
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #20000;
    nFail++;
    giveVerdict();
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int n, p, q;
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, writebackActive} = 6'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    {variantStrap, clockRatioStrap, writebackPatternStrap, busWidthStrap, endianStrap} = 10'h000;
    void'($urandom(32'hBC2B6805));
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      {sVar, sRatio, sPat, sBw, sEn} = 10'($urandom);
      if (i == 0) {sVar, sRatio, sPat} = 8'h00;
      if (i == 1) {sVar, sRatio, sPat} = {1'b0, 3'h7, 4'h9};
      if (i == 2) {sVar, sRatio, sPat} = {1'b1, 3'h6, 4'hF};
      rst <= 1'b1;
      writebackActive <= 1'b0;
      {variantStrap, clockRatioStrap, writebackPatternStrap, busWidthStrap, endianStrap} <= {sVar, sRatio, sPat, sBw, sEn};
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      writebackActive <= 1'b1;
      // straps move after reset and must be ignored
      {variantStrap, clockRatioStrap, writebackPatternStrap, busWidthStrap, endianStrap} <= ~{sVar, sRatio, sPat, sBw, sEn};
      polA = 3'($urandom);
      polB = 3'($urandom);
      wr(8'h00, {29'($urandom), polA}, r);
      chk("resp a", {30'h0, r}, 32'h0);
      wr(8'h04, {29'h1FFFFFFF, polB}, r);
      chk("resp b", {30'h0, r}, 32'h0);
      // lane 0 masked off: policy must stay as written before
      wstrb <= 4'hE;
      wr(8'h00, 32'hFFFFFFFF, r);
      wstrb <= 4'hF;
      wr(8'h0C, 32'hFFFFFFFF, r);
      chk("resp unmapped", {30'h0, r}, 32'h2);
      rd(8'h0C, d, r);
      chk("data unmapped", {d[29:0], r}, 32'h2);
      wr(8'h08, 32'hFFFFFFFF, r);
      chk("resp status", {30'h0, r}, 32'h0);
      rd(8'h08, d, r);
      chk("status", d & 32'hFFFFFFF7, {29'h0, sVar, sPat > 4'h8, sRatio == 3'h7}); // reserved codes
      rd(8'h00, d, r);
      chk("reg a", d, expReg(1'b0, polA)); // fields
      chk("rresp a", {30'h0, r}, 32'h0);
      rd(8'h04, d, r);
      chk("reg b", d, expReg(1'b1, polB)); // fields
      chk("policy out", {29'h0, unmappedSegmentCachePolicy}, {29'h0, sVar ? polB : polA});
      chk("beat word", {31'h0, writebackBeatIsWord}, {31'h0, sVar & sBw});
      n = 0;
      p = 0;
      q = 0;
      repeat (64) begin
        @(negedge clk);
        if (systemClockEnable) begin
          if (n > 0) chk("enable gap", 32'(q), 32'(sRatio) + 32'h2); // divided rate
          n++;
          q = 0;
        end
        q++;
        p += writebackSlot;
      end
      chk("enable seen", {31'h0, n > 0}, {31'h0, sRatio != 3'h7}); // reserved ratio
      chk("slots seen", {31'h0, p > 0}, {31'h0, sRatio != 3'h7 && sPat <= 4'h8}); // reserved
    end
    giveVerdict();
  end
endmodule // test_cpu_configuration_register
`default_nettype wire
